// ---- rtl/mfpm_pkg.sv ----
// Purpose: Shared constants and types of the pin and LED multiplexer
// Assumes: 25 MHz pclk, APB with 32-bit data
// Notes: Register offsets are byte addresses
package mfpm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_HALF_CYCLES = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BLINK_CNT_W = 21;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_GPIO_OUT = 5'h04;
  localparam logic [4:0] OFS_GPIO_OE = 5'h08;
  localparam logic [4:0] OFS_GPIO_IN = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_INT_STAT = 5'h14;
  localparam logic [4:0] OFS_INT_EN = 5'h18;
  localparam logic [4:0] OFS_INT_CLR = 5'h1C;
  localparam int CFG_REF_OUT = 1;
  localparam int CFG_WAKE_SEL = 12;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int GPIO_W = 9;
  localparam int INT_W = 3;
  localparam int INT_WAKE = 0;
  localparam int INT_LINK = 1;
  localparam int INT_COL = 2;
  // ----------------------------------------------------------------
  // Synchronised pin vector layout
  // ----------------------------------------------------------------
  localparam int PIN_W = 13;
  localparam int PIN_USB = 12;
  localparam int PIN_LINK = 11;
  localparam int PIN_SPD = 10;
  localparam int PIN_DUP = 9;
  localparam int PIN_GP0 = 8;
  // Upper group pin roles
  localparam int UP_RXD0 = 7;
  localparam int UP_RXD1 = 6;
  localparam int UP_REF = 5;
  localparam int UP_TXD0 = 4;
  localparam int UP_TXD1 = 3;
  localparam int UP_TXEN = 2;
  localparam int UP_CRSDV = 1;
  localparam int UP_GP = 0;
  localparam logic [7:0] UP_OUT_ROLES = 8'h1C;
  // ----------------------------------------------------------------
  // Operation modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INT_PHY = 3'b001,
    MODE_MAC_RMII = 3'b010,
    MODE_PHY_RMII = 3'b100
  } mfpm_mode_t;
endpackage : mfpm_pkg

// ---- rtl/mfpm_sync.sv ----
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to pclk
// Notes: Only the second stage leaves the module
`timescale 1ns/1ns
module mfpm_sync import mfpm_pkg::*; #(
  parameter int W = PIN_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mfpm_sync_st_t;
  mfpm_sync_st_t st_reg, st_next;

  // Shift one stage per enabled cycle
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : mfpm_sync

// ---- rtl/mfpm_blink.sv ----
// Purpose: Square wave for LED blinking
// Assumes: HALF is at least 2
// Notes: Phase flips every HALF enabled cycles
`timescale 1ns/1ns
module mfpm_blink import mfpm_pkg::*; #(
  parameter logic [BLINK_CNT_W-1:0] HALF = BLINK_CNT_W'(BLINK_HALF_CYCLES)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Phase
  output logic phase
);
  typedef struct packed {
    logic [BLINK_CNT_W-1:0] cnt;
    logic phase;
  } mfpm_blink_st_t;
  mfpm_blink_st_t st_reg, st_next;

  // Free-running divider; LEDs need no phase alignment
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      if (st_reg.cnt == HALF - BLINK_CNT_W'(1)) begin
        st_next.cnt = '0;
        st_next.phase = !st_reg.phase;
      end else begin
        st_next.cnt = st_reg.cnt + BLINK_CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase = st_reg.phase;
endmodule : mfpm_blink

// ---- rtl/mfpm_top.sv ----
// Purpose: Multi-function pin, strap and LED multiplexer with APB registers
// Assumes: Pins resolved outside from out/oe; straps pulled while undriven
// Notes: Pins stay undriven until straps are captured after reset
`timescale 1ns/1ns
module mfpm_top import mfpm_pkg::*; #(
  parameter logic [BLINK_CNT_W-1:0] BLINK_HALF = BLINK_CNT_W'(BLINK_HALF_CYCLES)
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Status from core logic
  input wire logic usb_high_speed,
  input wire logic bulk_out_active,
  input wire logic link_up,
  input wire logic phy_activity,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic wake_detected,
  // Core side of the RMII and management
  input wire logic [1:0] mac_tx_data,
  input wire logic mac_tx_en,
  input wire logic ref_clk_src,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe,
  input wire logic mgmt_clock_src,
  output logic [1:0] mac_rx_data,
  output logic mac_rx_valid,
  output logic ref_clk_in,
  output logic mgmt_data_in,
  output logic mgmt_clock_level,
  output logic mgmt_clock_rise,
  // Pins
  input wire logic usb_led_mode_strap_in,
  output logic usb_led_mode_strap_out,
  output logic usb_led_mode_strap_oe,
  input wire logic link_led_iface_strap_in,
  output logic link_led_iface_strap_out,
  output logic link_led_iface_strap_oe,
  input wire logic speed_led_mgmt_data_in,
  output logic speed_led_mgmt_data_out,
  output logic speed_led_mgmt_data_oe,
  input wire logic duplex_led_mgmt_clock_in,
  output logic duplex_led_mgmt_clock_out,
  output logic duplex_led_mgmt_clock_oe,
  input wire logic gp_pin_zero_wake_in,
  output logic gp_pin_zero_wake_out,
  output logic gp_pin_zero_wake_oe,
  input wire logic [7:0] upper_multifunction_group_in,
  output logic [7:0] upper_multifunction_group_out,
  output logic [7:0] upper_multifunction_group_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [GPIO_W-1:0] gpio_out;
    logic [GPIO_W-1:0] gpio_oe;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_en;
    logic [1:0] strap_cnt;
    logic strap_done;
    mfpm_mode_t mode;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [3:0] led_o;
    logic [3:0] led_oe;
    logic gp0_o;
    logic gp0_oe;
    logic [7:0] up_o;
    logic [7:0] up_oe;
    logic [1:0] rx_data;
    logic rx_valid;
    logic ref_in;
    logic mdio_in;
    logic mdc_lvl;
    logic mdc_rise;
    logic wake_q;
    logic link_q;
    logic col_q;
  } mfpm_st_t;
  mfpm_st_t st_reg, st_next;
  logic [PIN_W-1:0] pins_s;
  logic blink;
  logic acc;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;

  // ----------------------------------------------------------------
  // Synchronisers and blink source
  // ----------------------------------------------------------------
  mfpm_sync #(.W(PIN_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({usb_led_mode_strap_in, link_led_iface_strap_in, speed_led_mgmt_data_in,
        duplex_led_mgmt_clock_in, gp_pin_zero_wake_in, upper_multifunction_group_in}),
    .q(pins_s)
  );

  mfpm_blink #(.HALF(BLINK_HALF)) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .phase(blink)
  );

  // Access phase of an APB transfer completes when our pready is up
  assign acc = psel && penable && st_reg.pready;
  assign int_set = {collision && !st_reg.col_q, link_up != st_reg.link_q, wake_detected && !st_reg.wake_q};
  assign int_clr = (acc && pwrite && paddr[4:0] == OFS_INT_CLR) ? pwdata[INT_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      // Bus: one wait state, read data set together with pready
      st_next.pready = psel && penable && !st_reg.pready;
      if (psel && penable && !st_reg.pready) begin
        st_next.prdata = '0;
        st_next.pslverr = 1'b0;
        unique case (paddr[4:0])
          OFS_CFG: st_next.prdata[15:0] = st_reg.cfg;
          OFS_GPIO_OUT: st_next.prdata[GPIO_W-1:0] = st_reg.gpio_out;
          OFS_GPIO_OE: st_next.prdata[GPIO_W-1:0] = st_reg.gpio_oe;
          OFS_GPIO_IN: st_next.prdata[GPIO_W-1:0] = {pins_s[PIN_GP0-1:0], pins_s[PIN_GP0]};
          OFS_STATUS: st_next.prdata[4:0] = {st_reg.strap_done, 1'b0, st_reg.mode};
          OFS_INT_STAT: st_next.prdata[INT_W-1:0] = st_reg.int_stat;
          OFS_INT_EN: st_next.prdata[INT_W-1:0] = st_reg.int_en;
          OFS_INT_CLR: st_next.prdata = '0;
          default: st_next.pslverr = 1'b1;
        endcase
      end else if (acc) begin
        st_next.pslverr = 1'b0;
      end
      if (acc && pwrite) begin
        unique case (paddr[4:0])
          OFS_CFG: st_next.cfg = pwdata[15:0];
          OFS_GPIO_OUT: st_next.gpio_out = pwdata[GPIO_W-1:0];
          OFS_GPIO_OE: st_next.gpio_oe = pwdata[GPIO_W-1:0];
          OFS_INT_EN: st_next.int_en = pwdata[INT_W-1:0];
          default: st_next.cfg = st_reg.cfg;
        endcase
      end
      // Sticky events; a new event beats a clear in the same cycle
      st_next.int_stat = (st_reg.int_stat & ~int_clr) | int_set;
      st_next.irq = |(st_next.int_stat & st_next.int_en);
      st_next.wake_q = wake_detected;
      st_next.link_q = link_up;
      st_next.col_q = collision;
      // Straps: wait for the synchroniser to fill, then capture once
      if (!st_reg.strap_done) begin
        if (st_reg.strap_cnt == STRAP_WAIT) begin
          st_next.strap_done = 1'b1;
          st_next.mdc_lvl = pins_s[PIN_DUP]; // Preload so a pulled-up idle MDC shows no false rise
          if (pins_s[PIN_LINK]) begin
            st_next.mode = MODE_INT_PHY;
          end else if (pins_s[PIN_USB]) begin
            st_next.mode = MODE_MAC_RMII;
          end else begin
            st_next.mode = MODE_PHY_RMII;
          end
        end else begin
          st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
        end
        st_next.led_oe = '0;
        st_next.up_oe = '0;
        st_next.gp0_oe = 1'b0;
      end else begin
        // USB LED: float at full speed, low at high speed, blink on traffic
        st_next.led_o[3] = 1'b0;
        st_next.led_oe[3] = bulk_out_active ? blink : usb_high_speed;
        // Link LED
        st_next.led_oe[2] = 1'b1;
        st_next.led_o[2] = !link_up || (phy_activity && blink);
        // GP pin zero: plain GPIO or wake output
        if (st_reg.cfg[CFG_WAKE_SEL]) begin
          st_next.gp0_oe = 1'b1;
          st_next.gp0_o = wake_detected;
        end else begin
          st_next.gp0_oe = st_reg.gpio_oe[0];
          st_next.gp0_o = st_reg.gpio_out[0];
        end
        if (st_reg.mode == MODE_INT_PHY) begin
          st_next.led_oe[1] = 1'b1;
          st_next.led_o[1] = !speed_100;
          st_next.led_oe[0] = 1'b1;
          st_next.led_o[0] = !(full_duplex || collision);
          st_next.up_o = st_reg.gpio_out[GPIO_W-1:1];
          st_next.up_oe = st_reg.gpio_oe[GPIO_W-1:1];
          st_next.mdc_rise = 1'b0;
        end else begin
          // Management pins
          st_next.led_o[1] = mgmt_data_out;
          st_next.led_oe[1] = mgmt_data_oe;
          st_next.mdio_in = pins_s[PIN_SPD];
          if (st_reg.mode == MODE_MAC_RMII) begin
            st_next.led_oe[0] = 1'b1;
            st_next.led_o[0] = mgmt_clock_src;
            st_next.mdc_rise = 1'b0;
          end else begin
            // External MAC owns MDC; find its rising edges on our clock
            st_next.led_oe[0] = 1'b0;
            st_next.mdc_lvl = pins_s[PIN_DUP];
            st_next.mdc_rise = pins_s[PIN_DUP] && !st_reg.mdc_lvl;
          end
          // Upper group; both modes keep the same pin directions
          st_next.up_oe = UP_OUT_ROLES;
          st_next.up_o = '0;
          st_next.up_o[UP_TXD0] = mac_tx_data[0];
          st_next.up_o[UP_TXD1] = mac_tx_data[1];
          st_next.up_o[UP_TXEN] = mac_tx_en;
          st_next.rx_data = {pins_s[UP_RXD1], pins_s[UP_RXD0]};
          st_next.rx_valid = pins_s[UP_CRSDV];
          // Reference clock is driven when CFG_REF_OUT is set and always sampled; its edges are not resolved at 25 MHz
          st_next.up_oe[UP_REF] = st_reg.cfg[CFG_REF_OUT];
          st_next.up_o[UP_REF] = ref_clk_src;
          st_next.ref_in = pins_s[UP_REF];
          st_next.up_o[UP_GP] = st_reg.gpio_out[1];
          st_next.up_oe[UP_GP] = st_reg.gpio_oe[1];
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{cfg: CFG_RESET, mode: MODE_INT_PHY, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  assign usb_led_mode_strap_out = st_reg.led_o[3];
  assign usb_led_mode_strap_oe = st_reg.led_oe[3];
  assign link_led_iface_strap_out = st_reg.led_o[2];
  assign link_led_iface_strap_oe = st_reg.led_oe[2];
  assign speed_led_mgmt_data_out = st_reg.led_o[1];
  assign speed_led_mgmt_data_oe = st_reg.led_oe[1];
  assign duplex_led_mgmt_clock_out = st_reg.led_o[0];
  assign duplex_led_mgmt_clock_oe = st_reg.led_oe[0];
  assign gp_pin_zero_wake_out = st_reg.gp0_o;
  assign gp_pin_zero_wake_oe = st_reg.gp0_oe;
  assign upper_multifunction_group_out = st_reg.up_o;
  assign upper_multifunction_group_oe = st_reg.up_oe;
  assign mac_rx_data = st_reg.rx_data;
  assign mac_rx_valid = st_reg.rx_valid;
  assign ref_clk_in = st_reg.ref_in;
  assign mgmt_data_in = st_reg.mdio_in;
  assign mgmt_clock_level = st_reg.mdc_lvl;
  assign mgmt_clock_rise = st_reg.mdc_rise;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gp0_reset_input: assert property (@(posedge pclk) disable iff (!presetn)
    !st_reg.strap_done |-> !gp_pin_zero_wake_oe) else $error("gp pin zero driven before straps");
  a_wake_out_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && st_reg.cfg[CFG_WAKE_SEL] |=>
    gp_pin_zero_wake_oe && gp_pin_zero_wake_out == $past(wake_detected)) else $error("wake output wrong");
  a_usb_led_speed: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && !bulk_out_active |=>
    usb_led_mode_strap_oe == $past(usb_high_speed) && !usb_led_mode_strap_out) else $error("usb led speed wrong");
  a_usb_led_blink: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && bulk_out_active |=> usb_led_mode_strap_oe == $past(blink))
    else $error("usb led not blinking");
  a_strap_mode: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !st_reg.strap_done && st_reg.strap_cnt == STRAP_WAIT |=> st_reg.strap_done &&
    st_reg.mode == ($past(pins_s[PIN_LINK]) ? MODE_INT_PHY : $past(pins_s[PIN_USB]) ? MODE_MAC_RMII : MODE_PHY_RMII))
    else $error("strap decode wrong");
  a_link_led_up: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && link_up && !phy_activity |=> link_led_iface_strap_oe && !link_led_iface_strap_out)
    else $error("link led not low");
  a_upper_gpio: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && st_reg.mode == MODE_INT_PHY |=>
    upper_multifunction_group_oe == $past(st_reg.gpio_oe[GPIO_W-1:1])) else $error("upper group not gpio");
  a_speed_led: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && st_reg.mode == MODE_INT_PHY |=>
    speed_led_mgmt_data_oe && speed_led_mgmt_data_out == !$past(speed_100)) else $error("speed led wrong");
  a_mdc_direction: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.strap_done && st_reg.mode == MODE_PHY_RMII |-> !duplex_led_mgmt_clock_oe)
    else $error("mdc driven in phy mode");
  a_ref_direction: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && st_reg.mode != MODE_INT_PHY |=>
    upper_multifunction_group_oe[UP_REF] == $past(st_reg.cfg[CFG_REF_OUT])) else $error("ref clock direction wrong");
  a_rmii_txd_map: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_reg.strap_done && st_reg.mode != MODE_INT_PHY |=>
    upper_multifunction_group_out[UP_TXD0:UP_TXEN] == $past({mac_tx_data[0], mac_tx_data[1], mac_tx_en}))
    else $error("rmii mapping wrong");
  a_event_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ce && int_set[INT_WAKE] |=> st_reg.int_stat[INT_WAKE]) else $error("wake event lost");
endmodule : mfpm_top

// ---- tb/mfpm_far.sv ----
// Purpose: Far side of the pins: strap resistors, pulls and an external RMII peer
// Assumes: A pin nobody drives settles to its pull level
// Notes: Pin vector uses the package layout; MDC starts a new period only while mdc_run is high
`timescale 1ns/1ns
module mfpm_far import mfpm_pkg::*; (
  // Peer controls
  input wire logic strap_mode,
  input wire logic strap_iface,
  input wire logic mdc_run,
  input wire logic mdc_drv,
  input wire logic [7:0] up_drv,
  input wire logic [7:0] up_val,
  input wire logic mdio_drv,
  input wire logic mdio_val,
  // Device side
  input wire logic [PIN_W-1:0] dev_out,
  input wire logic [PIN_W-1:0] dev_oe,
  output logic [PIN_W-1:0] pin_in
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  logic mdc = 1'h0;
  logic [PIN_W-1:0] pull;
  logic [PIN_W-1:0] ext_drv;
  logic [PIN_W-1:0] ext_val;
  // Strap resistors on two LED pins, pull-down on GP pin zero, pull-ups elsewhere
  assign pull = {strap_mode, strap_iface, 2'h3, 1'h0, 8'hFF};
  // Peer drives MDC in PHY mode and the receive side of RMII
  assign ext_drv = {2'h0, mdio_drv, mdc_drv, 1'h0, up_drv};
  assign ext_val = {2'h0, mdio_val, mdc, 1'h0, up_val};
  // Device enable wins, then the peer, then the pull; no stale level survives a release
  assign pin_in = (dev_oe & dev_out) | (~dev_oe & ext_drv & ext_val) | (~dev_oe & ~ext_drv & pull);
  // Management clock stands low between frames, one whole period per pass
  // Edges sit half a pclk period away from the device's sampling edges
  always begin
    wait (mdc_run);
    #100 mdc = 1'h1;
    #160 mdc = 1'h0;
    #60;
  end
endmodule : mfpm_far

// ---- tb/test_mfpm_top.sv ----
// Purpose: Self-checking bench of the pin and LED multiplexer in all three strap modes
// Assumes: Blink half period shortened to 4 cycles
// Notes: Outputs are judged 1 ns after a clock edge after tick, and on the edge itself after an APB transfer
`timescale 1ns/1ns
module test_mfpm_top;
  import mfpm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [BLINK_CNT_W-1:0] HALF = BLINK_CNT_W'(4);
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic ce = 1'h1;
  logic psel, penable, pwrite, pready, pslverr, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic usb_hs, bulk, link_up, act, s100, fdx, col, wake;
  logic txen, refsrc, mdo, mdoe, mdcsrc, rxv, refin, mdi, mdcl, mdcr;
  logic [1:0] txd, rxd;
  wire [PIN_W-1:0] pout, poe;
  logic [PIN_W-1:0] pin;
  logic smode, siface, mrun, mdrv, mdvd, mdv;
  logic [7:0] upd, upv;
  int fails = 0;
  int checks_done = 0;
  int rises = 0;
  mfpm_top #(.BLINK_HALF(HALF)) i_mfpm_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .usb_high_speed(usb_hs), .bulk_out_active(bulk), .link_up(link_up), .phy_activity(act),
    .speed_100(s100), .full_duplex(fdx), .collision(col), .wake_detected(wake), .mac_tx_data(txd),
    .mac_tx_en(txen), .ref_clk_src(refsrc), .mgmt_data_out(mdo), .mgmt_data_oe(mdoe), .mgmt_clock_src(mdcsrc),
    .mac_rx_data(rxd), .mac_rx_valid(rxv), .ref_clk_in(refin), .mgmt_data_in(mdi), .mgmt_clock_level(mdcl),
    .mgmt_clock_rise(mdcr), .usb_led_mode_strap_in(pin[PIN_USB]), .usb_led_mode_strap_out(pout[PIN_USB]),
    .usb_led_mode_strap_oe(poe[PIN_USB]), .link_led_iface_strap_in(pin[PIN_LINK]),
    .link_led_iface_strap_out(pout[PIN_LINK]), .link_led_iface_strap_oe(poe[PIN_LINK]),
    .speed_led_mgmt_data_in(pin[PIN_SPD]), .speed_led_mgmt_data_out(pout[PIN_SPD]),
    .speed_led_mgmt_data_oe(poe[PIN_SPD]), .duplex_led_mgmt_clock_in(pin[PIN_DUP]),
    .duplex_led_mgmt_clock_out(pout[PIN_DUP]), .duplex_led_mgmt_clock_oe(poe[PIN_DUP]),
    .gp_pin_zero_wake_in(pin[PIN_GP0]), .gp_pin_zero_wake_out(pout[PIN_GP0]), .gp_pin_zero_wake_oe(poe[PIN_GP0]),
    .upper_multifunction_group_in(pin[7:0]), .upper_multifunction_group_out(pout[7:0]),
    .upper_multifunction_group_oe(poe[7:0]));
  mfpm_far i_mfpm_far (.strap_mode(smode), .strap_iface(siface), .mdc_run(mrun), .mdc_drv(mdrv),
    .up_drv(upd), .up_val(upv), .mdio_drv(mdvd), .mdio_val(mdv), .dev_out(pout), .dev_oe(poe), .pin_in(pin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    forever #20 pclk = ~pclk;
  end
  // Counts MDC rises seen by the design; scenarios compare differences only
  always @(posedge pclk) begin
    if (mdcr === 1'h1) rises <= rises + 1;
  end
  task automatic close_out;
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  // One APB transfer; waits for pready under a bound instead of assuming the wait state
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {27'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      fails++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // Straps are held on the pins across reset and the capture that follows it
  task automatic boot(input logic m, input logic i);
    @(posedge pclk);
    smode <= m;
    siface <= i;
    presetn <= 1'h0;
    tick(8);
    @(posedge pclk);
    presetn <= 1'h1;
    tick(8);
  endtask : boot
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_internal;
    int hi;
    int lh;
    boot(1'h0, 1'h1);
    rdchk(OFS_STATUS, 32'h11);
    rdchk(OFS_CFG, 32'h0);
    chk(poe[PIN_GP0], 1'h0);
    chk({poe[PIN_USB], pout[PIN_USB], poe[PIN_LINK], pout[PIN_LINK], poe[PIN_SPD], pout[PIN_SPD], poe[PIN_DUP],
         pout[PIN_DUP]}, 8'h3F);
    @(posedge pclk);
    {usb_hs, link_up, s100, fdx} <= 4'hF;
    tick(3);
    chk({poe[PIN_USB], pout[PIN_USB], poe[PIN_LINK], pout[PIN_LINK], poe[10], pout[10], poe[9], pout[9]}, 8'hAA);
    @(posedge pclk);
    {fdx, col} <= 2'h1;
    tick(3);
    chk(pout[PIN_DUP], 1'h0);
    rdchk(OFS_INT_STAT, 32'h6);
    // Two whole blink periods give exactly half the cycles in each phase, whatever the start phase
    @(posedge pclk);
    {bulk, act} <= 2'h3;
    tick(3);
    hi = 0;
    lh = 0;
    repeat (16) begin
      tick(1);
      if (poe[PIN_USB] === 1'h1) hi++;
      if (pout[PIN_LINK] === 1'h1) lh++;
    end
    chk(hi, 8);
    chk(lh, 8);
    // Clock enable low freezes the blink phase; four cycles would otherwise flip it
    @(posedge pclk);
    ce <= 1'h0;
    tick(1);
    hi = poe[PIN_USB];
    tick(4);
    chk(poe[PIN_USB], hi[0]);
    @(posedge pclk);
    ce <= 1'h1;
    apb(1'h1, OFS_INT_CLR, 32'h7);
    rdchk(OFS_INT_STAT, 32'h0);
    apb(1'h1, OFS_INT_EN, 32'h1);
    apb(1'h1, OFS_GPIO_OE, 32'h3);
    apb(1'h1, OFS_GPIO_OUT, 32'h2);
    tick(2);
    chk({poe[PIN_GP0], pout[PIN_GP0], poe[0], pout[0]}, 4'hB);
    rdchk(OFS_GPIO_IN, 32'h1FE);
    apb(1'h1, OFS_CFG, 32'h1000);
    @(posedge pclk);
    wake <= 1'h1;
    tick(3);
    chk({poe[PIN_GP0], pout[PIN_GP0], irq}, 3'h7);
    apb(1'h1, OFS_INT_EN, 32'h0);
    tick(2);
    chk(irq, 1'h0);
    apb(1'h1, OFS_INT_CLR, 32'h1);
    rdchk(OFS_INT_STAT, 32'h0);
    apb(1'h0, 5'h02, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
  endtask : t_internal
  task automatic t_mac;
    boot(1'h1, 1'h0);
    rdchk(OFS_STATUS, 32'h12);
    chk(poe[7:0], 8'h1C);
    @(posedge pclk);
    {txd, txen, mdoe, mdo, mdcsrc} <= 6'h2F;
    {upd, upv} <= 16'hC282;
    tick(4);
    chk({pout[4:2], rxd, rxv}, 6'h1B);
    chk({poe[PIN_SPD], pout[PIN_SPD], poe[PIN_DUP], pout[PIN_DUP]}, 4'hF);
    @(posedge pclk);
    {txd, txen, mdoe, mdo, mdcsrc, mdvd, mdv} <= 8'h42;
    upv <= 8'h40;
    tick(4);
    chk({pout[4:2], rxd, rxv}, 6'h24);
    chk({poe[PIN_SPD], mdi, poe[PIN_DUP], pout[PIN_DUP]}, 4'h2);
    apb(1'h1, OFS_CFG, 32'h2);
    @(posedge pclk);
    refsrc <= 1'h1;
    tick(3);
    chk({poe[7:0], pout[5]}, 9'h79);
  endtask : t_mac
  task automatic t_phy;
    int n0;
    boot(1'h0, 1'h0);
    rdchk(OFS_STATUS, 32'h14);
    chk({poe[PIN_DUP], poe[7:0]}, 9'h1C);
    @(posedge pclk);
    mdrv <= 1'h1;
    tick(4);
    n0 = rises;
    // Eight MDC periods at 320 ns, stopped inside the last period to avoid a race
    @(posedge pclk);
    mrun <= 1'h1;
    tick(62);
    mrun <= 1'h0;
    tick(12);
    chk(rises - n0, 8);
  endtask : t_phy
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, usb_hs, bulk, link_up, act, s100, fdx, col, wake} = '0;
    {txen, refsrc, mdo, mdoe, mdcsrc, mrun, mdrv, mdvd, mdv} = '0;
    {paddr, pwdata, txd, upd, upv} = '0;
    {smode, siface} = 2'h3;
    t_internal();
    t_mac();
    t_phy();
    close_out();
  end
endmodule : test_mfpm_top
